/* File: verilog/scco_params.svh */
// Timing, geometry and field constants for the speed compensated cam outputs.
// Assumes a 25 MHz system clock and a binary position from the shaft encoder.
// Functional notes
// R1 - Speed is measured continuously and switch points recomputed while running.
// R2 - Both switch-on and switch-off edges move earlier by the lead; in reverse the code moves them later.
// R3 - The lead is computed identically for either direction of rotation.
// R4 - The lead is strictly proportional to speed, no non-linear term.
// R5 - Lead in degrees equals delay seconds times rpm times 360 over 60.
// R6 - Each output has its own fixed delay; zero delay means no compensation.
// R7 - An output is active while position lies between a cam's on and off points.
// R8 - Delays are set in 100 us units, separately for on and off edges.
// R9 - Compensated points wrap modulo one revolution before comparison.
`ifndef SCCO_PARAMS_SVH
`define SCCO_PARAMS_SVH
`define SCCO_CLK_HZ        25000000
`define SCCO_POS_W         12
`define SCCO_POS_RANGE     12'hfff
`define SCCO_N_OUT         4
`define SCCO_N_CAM         2
`define SCCO_DLY_W         10
`define SCCO_DLY_UNIT_US   100
// A short window keeps the speed fresh; its resolution is one code per window.
`define SCCO_SPD_WIN_US    500
`define SCCO_SPD_WIN_CYC   (`SCCO_CLK_HZ / 1000000 * `SCCO_SPD_WIN_US)
`define SCCO_WIN_W         18
`define SCCO_SPD_W         12
`define SCCO_LEAD_DEN      (`SCCO_SPD_WIN_US / `SCCO_DLY_UNIT_US)
`define SCCO_LEAD_W        24
`endif

/* File: verilog/scco_pkg.sv */
// Types shared by the speed compensated cam output block.
// Assumes scco_params.svh sets the widths.
`include "scco_params.svh"
package scco_pkg;
   typedef logic [`SCCO_POS_W-1:0] scco_pos_t;
   typedef logic [`SCCO_DLY_W-1:0] scco_dly_t;
   typedef logic [`SCCO_SPD_W-1:0] scco_spd_t;
endpackage

/* File: verilog/scco_cam_if.sv */
// Carrier between the top and one cam comparator: present position and
// the compensated switch points of one cam.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface scco_cam_if;
   import scco_pkg::*;
   scco_pos_t pos;
   scco_pos_t on_pt;
   scco_pos_t off_pt;
   logic      hit;
   modport top (output pos, output on_pt, output off_pt, input hit);
   modport cmp (input pos, input on_pt, input off_pt, output hit);
endinterface

/* File: verilog/scco_cam_cmp.sv */
// One cam window comparator with wrap-around of the window across zero.
// Assumes points already reduced into one revolution.
`timescale 1ns/10ps
module scco_cam_cmp
   import scco_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   scco_cam_if.cmp   cam
);
   logic hit_reg;

   // A window whose off point lies below its on point spans the zero crossing.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hit_reg <= 1'b0;
      end else if (cam.on_pt <= cam.off_pt) begin
         hit_reg <= (cam.pos >= cam.on_pt) && (cam.pos < cam.off_pt); // R7
      end else begin
         hit_reg <= (cam.pos >= cam.on_pt) || (cam.pos < cam.off_pt); // R7
      end
   end
   assign cam.hit = hit_reg;
endmodule

/* File: verilog/scco_top.sv */
// Speed compensated cam outputs: measures shaft speed, moves each cam edge down in position
// by the angle travelled during its output's delay (earlier turning forward, later in reverse) and drives the outputs.
// Assumes position arrives from an asynchronous encoder interface, cam tables
// and delays are quasi-static inputs, and one revolution spans the full
// position code range.
`timescale 1ns/10ps
`include "scco_params.svh"
module scco_top
   import scco_pkg::*;
(
   input  wire logic                                       clk_i,
   input  wire logic                                       rst_i,
   input  wire logic [`SCCO_POS_W-1:0]                     pos_i,
   input  wire logic [`SCCO_N_OUT*`SCCO_N_CAM*`SCCO_POS_W-1:0] cam_on_i,
   input  wire logic [`SCCO_N_OUT*`SCCO_N_CAM*`SCCO_POS_W-1:0] cam_off_i,
   input  wire logic [`SCCO_N_OUT*`SCCO_DLY_W-1:0]         dly_on_i,
   input  wire logic [`SCCO_N_OUT*`SCCO_DLY_W-1:0]         dly_off_i,
   output logic      [`SCCO_SPD_W-1:0]                     speed_o,
   output logic      [`SCCO_N_OUT-1:0]                     out_o
);
   scco_pos_t                 pos_s1_reg;
   scco_pos_t                 pos_s2_reg;
   scco_pos_t                 pos_s3_reg;
   scco_pos_t                 pos_reg;
   scco_pos_t                 win_start_reg;
   logic [`SCCO_WIN_W-1:0]    win_cnt_reg;
   scco_spd_t                 speed_reg;
   scco_pos_t                 delta_fwd;
   scco_pos_t                 delta_rev;
   logic                      win_end;
   logic [`SCCO_N_OUT-1:0]    out_reg;
   logic [`SCCO_N_OUT*`SCCO_N_CAM-1:0] hit_all;

   // Three-stage synchroniser; a new position counts once stages two and three agree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_s1_reg <= '0;
         pos_s2_reg <= '0;
         pos_s3_reg <= '0;
      end else begin
         pos_s1_reg <= pos_i;
         pos_s2_reg <= pos_s1_reg;
         pos_s3_reg <= pos_s2_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_reg <= '0;
      end else if (pos_s2_reg == pos_s3_reg) begin
         pos_reg <= pos_s3_reg;
      end
   end

   // Speed is position codes travelled per measuring window, magnitude only,
   // so the lead does not depend on the direction of rotation.
   assign win_end   = (win_cnt_reg == `SCCO_WIN_W'(`SCCO_SPD_WIN_CYC - 1));
   assign delta_fwd = pos_reg - win_start_reg;
   assign delta_rev = win_start_reg - pos_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_cnt_reg <= '0;
      end else if (win_end) begin
         win_cnt_reg <= '0;
      end else begin
         win_cnt_reg <= win_cnt_reg + `SCCO_WIN_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_start_reg <= '0;
         speed_reg     <= '0;
      end else if (win_end) begin
         win_start_reg <= pos_reg; // R1
         // The shorter way round is taken as the motion, limiting speed to half a turn per window.
         speed_reg     <= (delta_fwd[`SCCO_POS_W-1]) ? delta_rev : delta_fwd; // R3
      end
   end
   assign speed_o = speed_reg;

   // Lead in codes = delay units * codes per window * unit / window length.
   // This is the travelled angle during the delay, linear in speed.
   function automatic scco_pos_t lead_of(input scco_dly_t dly, input scco_spd_t spd);
      logic [`SCCO_LEAD_W-1:0] prod;
      prod = `SCCO_LEAD_W'(dly) * `SCCO_LEAD_W'(spd); // R4 R5
      return scco_pos_t'(prod / `SCCO_LEAD_W'(`SCCO_LEAD_DEN)); // R5
   endfunction

   genvar go, gc;
   generate
      for (go = 0; go < `SCCO_N_OUT; go++) begin : g_out
         scco_pos_t lead_on_reg;
         scco_pos_t lead_off_reg;
         logic      out_bit_reg;
         // Leads follow every new speed value while the outputs keep switching.
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               lead_on_reg  <= '0;
               lead_off_reg <= '0;
            end else begin
               lead_on_reg  <= lead_of(dly_on_i[go*`SCCO_DLY_W +: `SCCO_DLY_W], speed_reg); // R1 R6 R8
               lead_off_reg <= lead_of(dly_off_i[go*`SCCO_DLY_W +: `SCCO_DLY_W], speed_reg); // R6 R8
            end
         end
         for (gc = 0; gc < `SCCO_N_CAM; gc++) begin : g_cam
            localparam int IDX = go*`SCCO_N_CAM + gc;
            scco_cam_if cam_bus ();
            assign cam_bus.pos    = pos_reg;
            // Subtraction in the position width wraps modulo one revolution.
            assign cam_bus.on_pt  = cam_on_i[IDX*`SCCO_POS_W +: `SCCO_POS_W] - lead_on_reg; // R2 R9
            assign cam_bus.off_pt = cam_off_i[IDX*`SCCO_POS_W +: `SCCO_POS_W] - lead_off_reg; // R2 R9
            assign hit_all[IDX]   = cam_bus.hit;
            scco_cam_cmp u_cmp (
               .clk_i (clk_i),
               .rst_i (rst_i),
               .cam   (cam_bus)
            );
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               out_bit_reg <= 1'b0;
            end else begin
               out_bit_reg <= |hit_all[go*`SCCO_N_CAM +: `SCCO_N_CAM]; // R7
            end
         end
         assign out_reg[go] = out_bit_reg;

         property p_zero_delay;
            @(posedge clk_i) disable iff (rst_i)
               (dly_on_i[go*`SCCO_DLY_W +: `SCCO_DLY_W] == '0) |=> (lead_on_reg == '0);
         endproperty
         a_zero_delay: assert property (p_zero_delay) else $error("zero delay gave lead"); // R6

         property p_lead_formula;
            @(posedge clk_i) disable iff (rst_i)
               1'b1 |=> (lead_on_reg ==
                  lead_of($past(dly_on_i[go*`SCCO_DLY_W +: `SCCO_DLY_W]), $past(speed_reg)));
         endproperty
         a_lead_formula: assert property (p_lead_formula) else $error("lead mismatch"); // R5

         sequence s_out_hit;
            |hit_all[go*`SCCO_N_CAM +: `SCCO_N_CAM];
         endsequence
         property p_out_follows;
            @(posedge clk_i) disable iff (rst_i) s_out_hit |=> out_reg[go];
         endproperty
         a_out_follows: assert property (p_out_follows) else $error("output missed cam"); // R7

         property p_out_idle;
            @(posedge clk_i) disable iff (rst_i)
               !(|hit_all[go*`SCCO_N_CAM +: `SCCO_N_CAM]) |=> !out_reg[go];
         endproperty
         a_out_idle: assert property (p_out_idle) else $error("output without cam"); // R7
      end
   endgenerate
   assign out_o = out_reg;

   property p_speed_update;
      @(posedge clk_i) disable iff (rst_i)
         win_end |=> (speed_reg == ($past(delta_fwd[`SCCO_POS_W-1]) ?
                                    $past(delta_rev) : $past(delta_fwd)));
   endproperty
   a_speed_update: assert property (p_speed_update) else $error("speed not updated"); // R1 R3

   property p_speed_hold;
      @(posedge clk_i) disable iff (rst_i) !win_end |=> $stable(speed_reg);
   endproperty
   a_speed_hold: assert property (p_speed_hold) else $error("speed changed mid window"); // R1

   property p_linear;
      @(posedge clk_i) disable iff (rst_i)
         lead_of(scco_dly_t'(10'h064), scco_spd_t'(12'h010)) * 2 ==
         lead_of(scco_dly_t'(10'h064), scco_spd_t'(12'h020));
   endproperty
   a_linear: assert property (p_linear) else $error("lead not linear"); // R4

   property p_sync_agree;
      @(posedge clk_i) disable iff (rst_i)
         (pos_s2_reg == pos_s3_reg) |=> (pos_reg == $past(pos_s3_reg));
   endproperty
   a_sync_agree: assert property (p_sync_agree) else $error("position not taken"); // R1

   property p_window_len;
      @(posedge clk_i) disable iff (rst_i)
         win_end |=> (win_cnt_reg == '0);
   endproperty
   a_window_len: assert property (p_window_len) else $error("window not restarted"); // R1
endmodule

/* File: sim/scco_enc_model.sv */
// Encoder stand-in: binary shaft position moving one code every period cycles.
// Assumes the block synchronises the position itself.
`timescale 1ns/10ps
module scco_enc_model
   import scco_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        set_i,
   input  wire scco_pos_t   set_pos_i,
   input  wire logic        rev_i,
   input  wire logic [15:0] period_i,
   output scco_pos_t        pos_o
);
   logic [15:0] cnt_reg;
   logic        step;
   // Compare with >= so that shortening the period never strands the count.
   assign step = period_i != 16'h0000 && cnt_reg >= period_i - 16'h0001;
   always_ff @(posedge clk_i) begin
      cnt_reg <= (rst_i || set_i || step) ? 16'h0000 : cnt_reg + 16'h0001;
      if (rst_i || set_i) begin
         pos_o <= set_pos_i;
      end else if (step) begin
         pos_o <= rev_i ? pos_o - 12'h001 : pos_o + 12'h001;
      end
   end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the speed compensated cam outputs.
// Assumes the encoder model and a speed window of 12500 cycles.
`timescale 1ns/10ps
`include "scco_params.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   import scco_pkg::*;
   typedef struct {scco_pos_t p; logic [3:0] o;} scco_row_t;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [95:0] cam_on = '0;
   logic [95:0] cam_off = '0;
   logic [39:0] dly_on = '0;
   logic [39:0] dly_off = '0;
   logic        do_set = 1'b0;
   logic        rev = 1'b0;
   logic [15:0] period = 16'h0000;
   scco_pos_t   set_val = 12'h000;
   scco_pos_t   pos;
   scco_spd_t   speed;
   logic [3:0]  outs;
   logic [3:0]  out_q = 4'h0;
   scco_pos_t   rise_pos [4];
   scco_pos_t   fall_pos [4];
   int          err_count = 0;
   int          tests_run = 0;
   int          don_v [4] = '{2, 0, 2, 4};
   int          doff_v [4] = '{2, 0, 0, 4};
   scco_row_t   rows [11] = '{'{12'h0ff, 4'h8}, '{12'h100, 4'h9}, '{12'h1ff, 4'h9},
      '{12'h200, 4'h8}, '{12'h80f, 4'h9}, '{12'hf00, 4'ha}, '{12'h00f, 4'ha},
      '{12'h010, 4'h8}, '{12'h400, 4'hc}, '{12'h401, 4'h8}, '{12'hfff, 4'h6}};
   scco_enc_model enc (.clk_i(clk_i), .rst_i(rst_i), .set_i(do_set), .set_pos_i(set_val),
      .rev_i(rev), .period_i(period), .pos_o(pos));
   scco_top uut (.clk_i(clk_i), .rst_i(rst_i), .pos_i(pos), .cam_on_i(cam_on),
      .cam_off_i(cam_off), .dly_on_i(dly_on), .dly_off_i(dly_off), .speed_o(speed),
      .out_o(outs));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic set_cam(input int o, input int k, input scco_pos_t on, input scco_pos_t off);
      cam_on[(o*2+k)*12 +: 12] <= on;
      cam_off[(o*2+k)*12 +: 12] <= off;
   endtask
   function automatic logic near(input scco_pos_t a, input scco_pos_t b);
      scco_pos_t d;
      d = a - b;
      return d < 12'h004 || d > 12'hffc;
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Edges are logged with the position that caused them; the encoder holds it long enough.
   always @(negedge clk_i) begin
      for (int o = 0; o < 4; o++) begin
         if (outs[o] === 1'b1 && out_q[o] === 1'b0) rise_pos[o] = pos;
         if (outs[o] === 1'b0 && out_q[o] === 1'b1) fall_pos[o] = pos;
      end
      out_q = outs;
   end
   // Lead in codes is delay times speed: dly * 100 us * (25e6 / per) codes per second.
   task automatic run_phase(input logic back, input logic [15:0] per);
      scco_pos_t c;
      scco_pos_t on;
      scco_pos_t off;
      scco_pos_t er [4];
      scco_pos_t ef [4];
      @(posedge clk_i);
      c = pos;
      `CHK("speed_o", 1'b1, near(speed, 12'(`SCCO_SPD_WIN_CYC / per)))
      for (int o = 0; o < 4; o++) begin
         on = back ? c - 12'h100 : c + 12'h1c0;
         off = on + 12'h060;
         set_cam(o, 0, on, off);
         set_cam(o, 1, 12'h000, 12'h000);
         on = on - 12'(don_v[o] * 2500 / per);
         off = off - 12'(doff_v[o] * 2500 / per);
         er[o] = back ? off - 12'h001 : on;
         ef[o] = back ? on - 12'h001 : off;
      end
      cycles(16000);
      for (int o = 0; o < 4; o++) begin
         `CHK("rise position", 1'b1, near(rise_pos[o], er[o]))
         `CHK("fall position", 1'b1, near(fall_pos[o], ef[o]))
      end
   endtask
   initial begin
      for (int o = 0; o < 4; o++) begin
         dly_on[o*10 +: 10] <= 10'(don_v[o]);
         dly_off[o*10 +: 10] <= 10'(doff_v[o]);
      end
      set_cam(0, 0, 12'h100, 12'h200);
      set_cam(0, 1, 12'h800, 12'h810);
      set_cam(1, 0, 12'hf00, 12'h010);
      set_cam(2, 0, 12'h400, 12'h401);
      set_cam(2, 1, 12'hfff, 12'h000);
      set_cam(3, 0, 12'h000, 12'hfff);
      cycles(19);
      @(negedge clk_i);
      `CHK("out_o in reset", 4'h0, outs)
      `CHK("speed_o in reset", 12'h000, speed)
      @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clk_i);
         do_set <= 1'b1;
         set_val <= rows[i].p;
         @(posedge clk_i);
         do_set <= 1'b0;
         cycles(10);
         @(negedge clk_i);
         `CHK("out_o", rows[i].o, outs)
      end
      @(posedge clk_i);
      do_set <= 1'b1;
      set_val <= 12'h7c4;
      period <= 16'h0019;
      @(posedge clk_i);
      do_set <= 1'b0;
      for (int i = 0; i < 26000 && speed === 12'h000; i++) begin
         @(posedge clk_i);
      end
      cycles(12510);
      run_phase(1'b0, 16'h0019);
      cycles(10);
      rev <= 1'b1;
      period <= 16'h0014;
      cycles(25000);
      run_phase(1'b1, 16'h0014);
      test_done();
   end
   initial begin
      cycles(100000);
      err_count++;
      test_done();
   end
endmodule
